// [rtl/tpcr_map.vh]
// register offsets, fields, reset values and timing counts of the port register bank
`ifndef TPCR_MAP_VH
`define TPCR_MAP_VH
`define TPCR_ADDR7 7'h25
`define TPCR_OFS_ID 8'h01
`define TPCR_OFS_ROLE 8'h02
`define TPCR_OFS_CTRL 8'h03
`define TPCR_OFS_FORCE 8'h04
`define TPCR_OFS_SRST 8'h05
`define TPCR_OFS_MASK 8'h10
`define TPCR_OFS_STAT 8'h11
`define TPCR_OFS_TYPE 8'h12
`define TPCR_OFS_EVT 8'h13
`define TPCR_RST_ROLE 8'h04
`define TPCR_RST_CTRL 8'h03
`define TPCR_RST_FORCE 8'h00
`define TPCR_RST_MASK 8'h00
`define TPCR_ROLE_MASK 8'h3F
`define TPCR_CTRL_MASK 8'h37
`define TPCR_FORCE_MASK 8'h0F
`define TPCR_EVT_MASK 8'h0F
`define TPCR_STAT_MASK 8'h3F
`define TPCR_TYPE_MASK 8'h1B
`define TPCR_BIT_INT_MASK 0
`define TPCR_BIT_ERR_REC 0
`define TPCR_BIT_DISABLE 1
`define TPCR_BIT_FORCE_UNATTACHED_SOURCE 2
`define TPCR_BIT_FORCE_UNATTACHED_SINK 3
`define TPCR_BIT_SOFT_RESET 0
`define TPCR_GLITCH_NS 50
`define TPCR_CLK_NS 20
`define TPCR_GLITCH_CYC ((`TPCR_GLITCH_NS + `TPCR_CLK_NS - 1) / `TPCR_CLK_NS + 1)
`define TPCR_SETUP_NS 1250
`define TPCR_SETUP_CYC ((`TPCR_SETUP_NS + `TPCR_CLK_NS - 1) / `TPCR_CLK_NS)
`endif

// [rtl/tpcr_regs.v]
// i2c target and register bank of the type-c port controller
`include "tpcr_map.vh"
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1 - scl and sda ignore pulses of 50 ns or less
// R2 - when stretching, next data bit is out 1250 ns before scl release
// R3 - one fixed seven-bit address; address lsb selects read or write
// R4 - read-only id: version in bits 7:4, revision in bits 3:0
// R5 - role bit 5 dual role with accessories, bit 4 without
// R6 - role bit 3 sink with accessories, bit 2 without
// R7 - role bit 1 source with accessories, bit 0 without
// R8 - role register resets to 04h, plain sink
// R9 - host ignores reserved bits when reading
// R10 - host never writes undefined offsets
// R11 - forced bits: disable, error recovery, unattached source, sink; others cleared
// R12 - global interrupt mask suppresses every interrupt
// R13 - soft reset bit resets whole controller and all registers
// R14 - host clears the disable bit itself
module tpcr_regs #(
	parameter VERSION = 4'h3, // arbitrary value
	parameter REVISION = 4'h5 // arbitrary value
) (
	input wire clk_sys,
	input wire rst,
	input wire clk_en,
	input wire scl_in,
	input wire sda_in,
	output reg scl_out,
	output reg scl_oe,
	output reg sda_out,
	output reg sda_oe,
	input wire [7:0] port_status,
	input wire [7:0] port_type,
	input wire [3:0] port_events,
	output reg [7:0] role_select,
	output reg [7:0] control_out,
	output reg force_disable,
	output reg force_error_recovery,
	output reg force_unattached_source,
	output reg force_unattached_sink,
	output reg irq_n,
	output reg soft_reset_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_ACK = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_RDATA = 3'h4;
	localparam ST_RACK = 3'h5;
	localparam ST_SKIP = 3'h6;
	localparam integer GL_I = `TPCR_GLITCH_CYC;
	localparam integer SU_I = `TPCR_SETUP_CYC;
	localparam [3:0] GL = GL_I[3:0];
	localparam [7:0] SU = SU_I[7:0];

	reg [3:0] scl_cnt_reg;
	reg [3:0] sda_cnt_reg;
	reg scl_f_reg;
	reg sda_f_reg;
	reg scl_d_reg;
	reg sda_d_reg;
	reg [2:0] st_reg;
	reg [3:0] bit_reg;
	reg [7:0] sh_reg;
	reg rw_reg;
	reg ptr_ok_reg;
	reg [7:0] ptr_reg;
	reg [7:0] mask_reg;
	reg [7:0] evt_reg;
	reg soft_reg;
	reg [7:0] rdata;
	reg [3:0] evt_next;
	wire scl_rise;
	wire scl_fall;
	wire start_c;
	wire stop_c;
	wire [3:0] fr_in;
	wire srst;

	assign scl_rise = scl_f_reg & ~scl_d_reg;
	assign scl_fall = ~scl_f_reg & scl_d_reg;
	assign start_c = scl_f_reg & scl_d_reg & ~sda_f_reg & sda_d_reg;
	assign stop_c = scl_f_reg & scl_d_reg & sda_f_reg & ~sda_d_reg;
	assign srst = soft_reg;

	// a level must persist more than 50 ns before the filter follows it
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_cnt_reg <= 4'h0;
			sda_cnt_reg <= 4'h0;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else if (clk_en) begin
			scl_d_reg <= scl_f_reg;
			sda_d_reg <= sda_f_reg;
			if (scl_in == scl_f_reg) begin
				scl_cnt_reg <= 4'h0;
			end else if (scl_cnt_reg == GL - 4'h1) begin
				scl_f_reg <= scl_in; // R1
				scl_cnt_reg <= 4'h0;
			end else begin
				scl_cnt_reg <= scl_cnt_reg + 4'h1;
			end
			if (sda_in == sda_f_reg) begin
				sda_cnt_reg <= 4'h0;
			end else if (sda_cnt_reg == GL - 4'h1) begin
				sda_f_reg <= sda_in; // R1
				sda_cnt_reg <= 4'h0;
			end else begin
				sda_cnt_reg <= sda_cnt_reg + 4'h1;
			end
		end
	end

	always @* begin
		case (ptr_reg)
		`TPCR_OFS_ID: rdata = {VERSION, REVISION}; // R4
		`TPCR_OFS_ROLE: rdata = role_select;
		`TPCR_OFS_CTRL: rdata = control_out;
		`TPCR_OFS_FORCE: rdata = {4'h0, force_unattached_sink,
			force_unattached_source, force_disable,
			force_error_recovery};
		`TPCR_OFS_SRST: rdata = 8'h00;
		`TPCR_OFS_MASK: rdata = mask_reg;
		`TPCR_OFS_STAT: rdata = port_status & `TPCR_STAT_MASK;
		`TPCR_OFS_TYPE: rdata = port_type & `TPCR_TYPE_MASK;
		`TPCR_OFS_EVT: rdata = evt_reg;
		default: rdata = 8'h00;
		endcase
	end

	assign fr_in = sh_reg[3:0];

	// events set sticky flags; a read of the flag register clears them
	always @* begin
		evt_next = evt_reg[3:0];
		if (st_reg == ST_RDATA && bit_reg == 4'h0 && scl_fall &&
			ptr_reg == `TPCR_OFS_EVT) begin
			evt_next = 4'h0;
		end
		evt_next = evt_next | port_events;
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			rw_reg <= 1'b0;
			ptr_ok_reg <= 1'b0;
			ptr_reg <= 8'h00;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			scl_out <= 1'b0;
			scl_oe <= 1'b0;
			role_select <= `TPCR_RST_ROLE; // R8
			control_out <= `TPCR_RST_CTRL;
			mask_reg <= `TPCR_RST_MASK;
			evt_reg <= 8'h00;
			force_disable <= 1'b0;
			force_error_recovery <= 1'b0;
			force_unattached_source <= 1'b0;
			force_unattached_sink <= 1'b0;
			soft_reg <= 1'b0;
			soft_reset_out <= 1'b0;
			irq_n <= 1'b1;
		end else if (clk_en) begin
			soft_reset_out <= srst;
			soft_reg <= 1'b0;
			// one-shot forcing bits clear after a cycle; disable stays
			force_error_recovery <= 1'b0;
			force_unattached_source <= 1'b0;
			force_unattached_sink <= 1'b0;
			evt_reg <= {4'h0, evt_next};
			// R12
			irq_n <= ~(|(evt_next & ~mask_reg[3:0]) &
				~control_out[`TPCR_BIT_INT_MASK]);
			if (srst) begin
				// R13
				st_reg <= ST_IDLE;
				sda_oe <= 1'b0;
				ptr_reg <= 8'h00;
				role_select <= `TPCR_RST_ROLE;
				control_out <= `TPCR_RST_CTRL;
				mask_reg <= `TPCR_RST_MASK;
				evt_reg <= 8'h00;
				force_disable <= 1'b0;
			end else if (start_c) begin
				st_reg <= ST_ADDR;
				bit_reg <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				st_reg <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st_reg)
				ST_ADDR, ST_WDATA: begin
					if (scl_rise) begin
						sh_reg <= {sh_reg[6:0], sda_f_reg};
						bit_reg <= bit_reg + 4'h1;
					end else if (scl_fall && bit_reg == 4'h8) begin
						bit_reg <= 4'h0;
						if (st_reg == ST_ADDR) begin
							if (sh_reg[7:1] == `TPCR_ADDR7) begin
								rw_reg <= sh_reg[0]; // R3
								ptr_ok_reg <= 1'b0;
								st_reg <= ST_ACK;
								sda_oe <= 1'b1;
							end else begin
								st_reg <= ST_SKIP;
							end
						end else begin
							st_reg <= ST_ACK;
							sda_oe <= 1'b1;
							if (!ptr_ok_reg) begin
								ptr_reg <= sh_reg;
								ptr_ok_reg <= 1'b1;
							end else begin
								ptr_reg <= ptr_reg + 8'h01;
								case (ptr_reg)
								// R5 R6 R7
								`TPCR_OFS_ROLE: role_select <= sh_reg &
									`TPCR_ROLE_MASK;
								`TPCR_OFS_CTRL: control_out <= sh_reg &
									`TPCR_CTRL_MASK;
								`TPCR_OFS_MASK: mask_reg <= sh_reg &
									`TPCR_EVT_MASK;
								`TPCR_OFS_SRST: soft_reg <=
									sh_reg[`TPCR_BIT_SOFT_RESET];
								`TPCR_OFS_FORCE: begin
									// R11
									force_disable <= fr_in[`TPCR_BIT_DISABLE];
									force_error_recovery <=
										~fr_in[1] & fr_in[0];
									force_unattached_source <=
										~fr_in[1] & ~fr_in[0] & fr_in[2];
									force_unattached_sink <=
										(fr_in[2:0] == 3'h0) & fr_in[3];
								end
								// writes to undefined offsets are dropped
								default: ;
								endcase
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							st_reg <= ST_RDATA;
							sh_reg <= rdata;
							sda_oe <= ~rdata[7];
						end else begin
							st_reg <= ST_WDATA;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_reg == 4'h7) begin
							bit_reg <= 4'h0;
							sda_oe <= 1'b0;
							st_reg <= ST_RACK;
							ptr_reg <= ptr_reg + 8'h01;
						end else begin
							bit_reg <= bit_reg + 4'h1;
							sh_reg <= {sh_reg[6:0], 1'b0};
							sda_oe <= ~sh_reg[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						st_reg <= sda_f_reg ? ST_SKIP : ST_ACK;
						rw_reg <= 1'b1;
					end
				end
				ST_SKIP: sda_oe <= 1'b0;
				default: st_reg <= ST_IDLE;
				endcase
			end
			// never stretches: data changes at scl fall, long before release
			scl_oe <= 1'b0; // R2
			scl_out <= (SU == 8'h00);
		end
	end
endmodule // tpcr_regs
`default_nettype wire

// [testbench/tpcr_regs_properties.sv]
// assertions on the port register bank outputs
`timescale 1ns/100ps
`default_nettype none
module tpcr_regs_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic [7:0] role_select,
	input wire logic [7:0] control_out,
	input wire logic force_disable,
	input wire logic force_error_recovery,
	input wire logic force_unattached_source,
	input wire logic force_unattached_sink,
	input wire logic irq_n,
	input wire logic soft_reset_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire fp = force_error_recovery | force_unattached_source |
		force_unattached_sink;
	sequence srst_s;
		soft_reset_out ##1 !soft_reset_out;
	endsequence
	no_stretch_a: assert property (!scl_oe)
		else $error("scl held low");
	ack_timing_a: assert property ($rose(sda_oe) |->
		!scl_in && !$past(scl_in, 3)) else $error("sda moved early");
	reset_value_a: assert property ($fell(rst) |->
		role_select == 8'h04 && control_out == 8'h03) else $error("reset");
	role_reserved_a: assert property (role_select[7:6] == 2'h0)
		else $error("role reserved bits set");
	force_onehot_a: assert property ($onehot0({force_disable,
		force_error_recovery, force_unattached_source,
		force_unattached_sink}))
		else $error("two forced states");
	force_pulse_a: assert property (fp |=> !fp)
		else $error("forced pulse too long");
	int_mask_a: assert property (control_out[0] [*2] |-> irq_n)
		else $error("interrupt not masked");
	soft_reset_a: assert property ($rose(soft_reset_out) |->
		srst_s ##[0:1] (role_select == 8'h04 && control_out == 8'h03))
		else $error("soft reset incomplete");
endmodule // tpcr_regs_properties
bind tpcr_regs tpcr_regs_properties chk (.clk_sys, .rst, .scl_in, .scl_oe,
	.sda_oe, .role_select, .control_out, .force_disable, .force_error_recovery,
	.force_unattached_source, .force_unattached_sink, .irq_n, .soft_reset_out);
`default_nettype wire

// [testbench/tpcr_host.sv]
// i2c controller model standing for the host processor
`include "tpcr_map.vh"
`timescale 1ns/100ps
`default_nettype none
module tpcr_host (
	input wire logic clk_sys,
	input wire logic sda,
	output var logic scl_lo,
	output var logic sda_lo
);
	event got;
	logic [7:0] rdat;
	logic nak = 0;
	initial scl_lo = 0;
	initial sda_lo = 0;
	task q;
		repeat (33) @(posedge clk_sys);
		#1;
	endtask
	// half of the scl high time, keeps the run short
	task h;
		repeat (16) @(posedge clk_sys);
		#1;
	endtask
	task sta;
		sda_lo = 0;
		q;
		scl_lo = 0;
		q;
		sda_lo = 1;
		q;
		scl_lo = 1;
	endtask
	task sto;
		sda_lo = 1;
		q;
		scl_lo = 0;
		q;
		sda_lo = 0;
		q;
	endtask
	task bt(input logic b, output logic r);
		sda_lo = !b;
		q;
		scl_lo = 0;
		h;
		r = sda;
		h;
		scl_lo = 1;
		q;
	endtask
	task by(input logic [7:0] d, input logic c);
		logic a;
		for (int i = 7; i >= 0; i--) bt(d[i], rdat[i]);
		bt(1'b1, a);
		if (c) nak = nak | a;
	endtask
	// only defined offsets are written
	task wr(input logic [7:0] o, input logic [7:0] d);
		nak = 0;
		sta;
		by({`TPCR_ADDR7, 1'b0}, 1'b1);
		by(o, 1'b1);
		by(d, 1'b1);
		sto;
	endtask
	task rd(input logic [7:0] o);
		nak = 0;
		sta;
		by({`TPCR_ADDR7, 1'b0}, 1'b1);
		by(o, 1'b1);
		sta;
		by({`TPCR_ADDR7, 1'b1}, 1'b1);
		by(8'hFF, 1'b0);
		sto;
		->got;
	endtask
endmodule // tpcr_host
`default_nettype wire

// [testbench/tpcr_regs_tb.sv]
// self-checking bench of the port register bank
`include "tpcr_map.vh"
`timescale 1ns/100ps
`default_nettype none
module tpcr_regs_tb;
	logic clk_sys = 0;
	logic rst = 1;
	logic [7:0] port_status = 0;
	logic [7:0] port_type = 0;
	logic [3:0] port_events = 0;
	logic [7:0] v;
	logic [7:0] expq[$];
	wire [7:0] role_select, control_out;
	wire scl_out, scl_oe, sda_out, sda_oe, scl_lo, sda_lo, irq_n;
	wire force_disable, force_error_recovery, force_unattached_source;
	wire force_unattached_sink, soft_reset_out;
	wire scl = !(scl_lo | scl_oe & !scl_out);
	wire sda = !(sda_lo | sda_oe & !sda_out);
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [7:0] pulse_seen = 0;
	always #10 clk_sys = ~clk_sys;
	// remembers every one-cycle forcing pulse seen so far
	always @(posedge clk_sys)
		pulse_seen <= pulse_seen | {5'h0, force_unattached_sink,
			force_unattached_source, force_error_recovery};
	tpcr_regs #(.VERSION(4'hA), .REVISION(4'h6)) uut (.clk_sys, .rst,
		.clk_en(1'b1), .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe,
		.sda_out, .sda_oe, .port_status, .port_type, .port_events,
		.role_select, .control_out, .force_disable, .force_error_recovery,
		.force_unattached_source, .force_unattached_sink, .irq_n,
		.soft_reset_out);
	tpcr_host host (.clk_sys, .sda(sda), .scl_lo, .sda_lo);
	task chk(input logic [7:0] s, input logic [7:0] e, input string nm);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] o, input logic [7:0] d);
		host.wr(o, d);
		chk({7'h0, host.nak}, 8'h00, "ack");
	endtask
	task rd(input logic [7:0] o, input logic [7:0] e);
		expq.push_back(e);
		host.rd(o);
	endtask
	always @(host.got) chk(host.rdat, expq.pop_front(), "read");
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			final_report;
		end
	end
	initial begin
		v = $urandom(41723);
		repeat (12) @(posedge clk_sys);
		#1 rst = 0;
		repeat (2) @(posedge clk_sys);
		rd(`TPCR_OFS_ID, 8'hA6);
		rd(`TPCR_OFS_ROLE, `TPCR_RST_ROLE);
		rd(`TPCR_OFS_CTRL, `TPCR_RST_CTRL);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			wr(`TPCR_OFS_ROLE, 8'h01 << i);
			chk(role_select, 8'h01 << i, "role");
		end
		$display("role test done");
		port_status = $urandom;
		port_type = $urandom;
		v = $urandom;
		wr(`TPCR_OFS_MASK, v);
		rd(`TPCR_OFS_MASK, v & 8'h0F);
		rd(`TPCR_OFS_STAT, port_status & 8'h3F);
		rd(`TPCR_OFS_TYPE, port_type & 8'h1B);
		$display("status test done");
		wr(`TPCR_OFS_FORCE, 8'h0F);
		chk({7'h0, force_disable}, 8'h01, "disable");
		chk(pulse_seen, 8'h00, "pulse");
		wr(`TPCR_OFS_FORCE, 8'h00);
		chk({7'h0, force_disable}, 8'h00, "disable");
		wr(`TPCR_OFS_FORCE, 8'h0C);
		chk(pulse_seen, 8'h02, "pulse");
		$display("force test done");
		wr(`TPCR_OFS_MASK, 8'h00);
		wr(`TPCR_OFS_CTRL, 8'h00);
		port_events = 4'h1;
		@(posedge clk_sys);
		#1 port_events = 4'h0;
		repeat (4) @(posedge clk_sys);
		chk({7'h0, irq_n}, 8'h00, "irq_n");
		wr(`TPCR_OFS_CTRL, 8'h01);
		chk({7'h0, irq_n}, 8'h01, "irq_n");
		rd(`TPCR_OFS_EVT, 8'h01);
		$display("event test done");
		host.nak = 0;
		host.sta;
		host.by({`TPCR_ADDR7 ^ 7'h01, 1'b0}, 1'b1);
		host.sto;
		chk({7'h0, host.nak}, 8'h01, "nack");
		host.wr(`TPCR_OFS_SRST, 8'h01);
		rd(`TPCR_OFS_ROLE, `TPCR_RST_ROLE);
		rd(`TPCR_OFS_CTRL, `TPCR_RST_CTRL);
		$display("address and soft reset test done");
		@(posedge clk_sys);
		final_report;
	end
endmodule // tpcr_regs_tb
`default_nettype wire
